/* File: async_timer_consts.vh */
// Constants for the asynchronous timer with staged writes and prescaler.
// Assumes a 32-bit Avalon-MM slave port with byte addresses and one word
// per register.
`ifndef ASYNC_TIMER_CONSTS_VH
`define ASYNC_TIMER_CONSTS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_COUNTER 5'h00
`define OFS_CMP_A 5'h04
`define OFS_CMP_B 5'h08
`define OFS_CTRL_A 5'h0c
`define OFS_CTRL_B 5'h10
`define OFS_STATUS 5'h14
`define OFS_GEN_CTRL 5'h18
`define OFS_FLAGS 5'h1c
`define OFS_IRQ_EN 5'h20

// ****************************************************************
// Staged register indices
// ****************************************************************
`define NUM_STAGED 5
`define IDX_COUNTER 3'h0
`define IDX_CMP_A 3'h1
`define IDX_CMP_B 3'h2
`define IDX_CTRL_A 3'h3
`define IDX_CTRL_B 3'h4

// ****************************************************************
// Status register fields
// ****************************************************************
`define ST_CTRL_B_BUSY 0
`define ST_CTRL_A_BUSY 1
`define ST_CMP_B_BUSY 2
`define ST_CMP_A_BUSY 3
`define ST_CNT_BUSY 4
`define ST_ASYNC_SEL 5
`define ST_EXT_CLK 6
`define ST_REGS_LOST 7

// ****************************************************************
// Other fields
// ****************************************************************
`define GEN_PSC_RESET 1
`define FLG_OVF 0
`define FLG_CMP_A 1
`define FLG_CMP_B 2
`define CTRL_A_TOGGLE_A 6
`define CTRL_B_CS_HI 2
`define CTRL_B_CS_LO 0

// ****************************************************************
// Prescaler selections and masks
// ****************************************************************
`define CS_STOP 3'h0
`define CS_DIV1 3'h1
`define CS_DIV8 3'h2
`define CS_DIV32 3'h3
`define CS_DIV64 3'h4
`define CS_DIV128 3'h5
`define CS_DIV256 3'h6
`define CS_DIV1024 3'h7
`define PSC_M1 10'h000
`define PSC_M8 10'h007
`define PSC_M32 10'h01f
`define PSC_M64 10'h03f
`define PSC_M128 10'h07f
`define PSC_M256 10'h0ff
`define PSC_M1024 10'h3ff

// ****************************************************************
// Widths, reset values and counts
// ****************************************************************
`define BYTE_ZERO 8'h00
`define BYTE_MAX 8'hff
`define COMMIT_EDGES 2'h2
`define FLAG_SYNC_STAGES 3

`endif

/* File: async_timer_sync_prescaler.v */
// Asynchronous 8-bit timer core: staged register writes with busy flags,
// counter read-back holding register, flag synchronisation, clock source
// selection and prescaler.
// Assumes a 10 MHz system clock more than four times the oscillator rate,
// and an oscillator pin that is asynchronous to it.
`timescale 1ns/1ns
`include "async_timer_consts.vh"
`default_nettype none

module async_timer_sync_prescaler (
	// Clock and reset
	input wire sys_clk_i,
	input wire resetn_i,
	// Avalon-MM slave
	input wire [4:0] address_i,
	input wire read_i,
	input wire write_i,
	input wire [31:0] writedata_i,
	output reg [31:0] readdata_o,
	output reg waitrequest_o,
	// Oscillator pin and power state
	input wire osc_input_pin_i,
	input wire power_save_i,
	input wire power_down_i,
	// Pin and system controls
	output reg osc_enable_o,
	output reg osc_amp_enable_o,
	output reg osc_port_detach_o,
	output reg compare_out_o,
	output reg wake_request_o
);

	// ****************************************************************
	// Oscillator synchroniser and timer source edge
	// ****************************************************************
	reg osc_meta_q;
	reg osc_sync_q;
	reg osc_prev_q;
	reg async_sel_q;
	reg ext_clk_q;
	wire osc_rise;
	wire src_edge;

	always @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			osc_meta_q <= 1'b0;
			osc_sync_q <= 1'b0;
			osc_prev_q <= 1'b0;
		end else begin
			osc_meta_q <= osc_input_pin_i;
			osc_sync_q <= osc_meta_q;
			osc_prev_q <= osc_sync_q;
		end
	end

	assign osc_rise = osc_sync_q & ~osc_prev_q;
	// The I/O clock is the source by default, so every cycle is an edge.
	assign src_edge = async_sel_q ? osc_rise : 1'b1;

	// ****************************************************************
	// Bus decode
	// ****************************************************************
	wire bus_req;
	wire wr_fire;
	reg [2:0] wr_idx;
	reg wr_staged;

	assign bus_req = read_i | write_i;
	assign wr_fire = write_i & ~waitrequest_o;

	always @* begin
		wr_staged = wr_fire;
		wr_idx = `IDX_COUNTER;
		case (address_i)
		`OFS_COUNTER: wr_idx = `IDX_COUNTER;
		`OFS_CMP_A: wr_idx = `IDX_CMP_A;
		`OFS_CMP_B: wr_idx = `IDX_CMP_B;
		`OFS_CTRL_A: wr_idx = `IDX_CTRL_A;
		`OFS_CTRL_B: wr_idx = `IDX_CTRL_B;
		default: wr_staged = 1'b0;
		endcase
	end

	// ****************************************************************
	// Staging, busy flags and destinations
	// ****************************************************************
	reg [7:0] stage_q [0:`NUM_STAGED-1];
	reg [7:0] dest_q [0:`NUM_STAGED-1];
	reg [1:0] edge_cnt_q [0:`NUM_STAGED-1];
	reg [`NUM_STAGED-1:0] busy_q;
	reg [9:0] psc_q;
	reg psc_reset_q;
	reg timer_tick;
	reg [9:0] psc_mask;
	reg cmp_a_hit;
	reg cmp_b_hit;
	reg ovf_hit;
	reg regs_lost_q;
	reg power_down_prev_q;
	integer i;

	always @* begin
		case (dest_q[`IDX_CTRL_B][`CTRL_B_CS_HI:`CTRL_B_CS_LO])
		`CS_DIV1: psc_mask = `PSC_M1;
		`CS_DIV8: psc_mask = `PSC_M8;
		`CS_DIV32: psc_mask = `PSC_M32;
		`CS_DIV64: psc_mask = `PSC_M64;
		`CS_DIV128: psc_mask = `PSC_M128;
		`CS_DIV256: psc_mask = `PSC_M256;
		`CS_DIV1024: psc_mask = `PSC_M1024;
		default: psc_mask = `PSC_M1;
		endcase
		timer_tick = src_edge & ~psc_reset_q &
			(dest_q[`IDX_CTRL_B][`CTRL_B_CS_HI:`CTRL_B_CS_LO] != `CS_STOP) &
			((psc_q & psc_mask) == psc_mask);
		// A pending counter or compare write blocks the match.
		cmp_a_hit = timer_tick & ~busy_q[`IDX_COUNTER] &
			~busy_q[`IDX_CMP_A] &
			(dest_q[`IDX_COUNTER] == dest_q[`IDX_CMP_A]);
		cmp_b_hit = timer_tick & ~busy_q[`IDX_COUNTER] &
			~busy_q[`IDX_CMP_B] &
			(dest_q[`IDX_COUNTER] == dest_q[`IDX_CMP_B]);
		ovf_hit = timer_tick & ~busy_q[`IDX_COUNTER] &
			(dest_q[`IDX_COUNTER] == `BYTE_MAX);
	end

	always @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			busy_q <= {`NUM_STAGED{1'b0}};
			for (i = 0; i < `NUM_STAGED; i = i + 1) begin
				stage_q[i] <= `BYTE_ZERO;
				dest_q[i] <= `BYTE_ZERO;
				edge_cnt_q[i] <= 2'h0;
			end
		end else begin
			if (timer_tick)
				dest_q[`IDX_COUNTER] <= dest_q[`IDX_COUNTER] + 8'h01;
			for (i = 0; i < `NUM_STAGED; i = i + 1) begin
				if (wr_staged && wr_idx == i[2:0]) begin
					stage_q[i] <= writedata_i[7:0];
					busy_q[i] <= 1'b1;
					edge_cnt_q[i] <= 2'h0;
				end else if (busy_q[i] && src_edge) begin
					if (edge_cnt_q[i] == `COMMIT_EDGES - 2'h1) begin
						dest_q[i] <= stage_q[i];
						busy_q[i] <= 1'b0;
					end else begin
						edge_cnt_q[i] <= edge_cnt_q[i] + 2'h1;
					end
				end
			end
		end
	end

	// ****************************************************************
	// Prescaler
	// ****************************************************************
	always @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			psc_q <= 10'h000;
		end else if (psc_reset_q) begin
			psc_q <= 10'h000;
		end else if (src_edge) begin
			psc_q <= psc_q + 10'h001;
		end
	end

	// ****************************************************************
	// Counter read-back holding register
	// ****************************************************************
	reg [7:0] cnt_hold_q;

	always @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			cnt_hold_q <= `BYTE_ZERO;
		else if (src_edge)
			cnt_hold_q <= dest_q[`IDX_COUNTER];
	end

	// ****************************************************************
	// Flag synchronisation, wake-up and compare output
	// ****************************************************************
	// Events are caught at the timer edge and then walk a short pipeline
	// so that, with the I/O clock as source, software never sees a flag before the counter has moved on.
	reg [2:0] evt_q [0:`FLAG_SYNC_STAGES-1];
	reg [2:0] flags_q;
	reg [2:0] irq_en_q;
	reg armed_q;
	wire flg_clr;
	wire [2:0] evt_now;

	assign flg_clr = wr_fire & (address_i == `OFS_FLAGS);
	assign evt_now = {cmp_b_hit, cmp_a_hit, ovf_hit};

	always @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			for (i = 0; i < `FLAG_SYNC_STAGES; i = i + 1)
				evt_q[i] <= 3'h0;
			flags_q <= 3'h0;
			armed_q <= 1'b1;
			wake_request_o <= 1'b0;
			compare_out_o <= 1'b0;
		end else begin
			evt_q[0] <= evt_now;
			for (i = 1; i < `FLAG_SYNC_STAGES; i = i + 1)
				evt_q[i] <= evt_q[i-1];
			// A new event wins over a clear in the same cycle.
			flags_q <= (flags_q & ~({3{flg_clr}} & writedata_i[2:0])) |
				evt_q[`FLAG_SYNC_STAGES-1];
			if (cmp_a_hit && dest_q[`IDX_CTRL_A][`CTRL_A_TOGGLE_A])
				compare_out_o <= ~compare_out_o;
			wake_request_o <= 1'b0;
			if (wake_request_o) begin
				armed_q <= 1'b0;
			end else if (!armed_q) begin
				if (src_edge)
					armed_q <= 1'b1;
			end else if (power_save_i && src_edge &&
				((flags_q & irq_en_q) != 3'h0)) begin
				wake_request_o <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// Control registers and oscillator control
	// ****************************************************************
	always @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			async_sel_q <= 1'b0;
			ext_clk_q <= 1'b0;
			irq_en_q <= 3'h0;
			psc_reset_q <= 1'b0;
			regs_lost_q <= 1'b0;
			power_down_prev_q <= 1'b0;
			osc_enable_o <= 1'b0;
			osc_amp_enable_o <= 1'b0;
			osc_port_detach_o <= 1'b0;
		end else begin
			power_down_prev_q <= power_down_i;
			psc_reset_q <= wr_fire && address_i == `OFS_GEN_CTRL &&
				writedata_i[`GEN_PSC_RESET];
			if (wr_fire && address_i == `OFS_STATUS) begin
				// Contents are not cleaned on a switch; software rewrites.
				async_sel_q <= writedata_i[`ST_ASYNC_SEL];
				ext_clk_q <= writedata_i[`ST_EXT_CLK];
			end
			if (wr_fire && address_i == `OFS_IRQ_EN)
				irq_en_q <= writedata_i[2:0];
			if (power_down_prev_q && !power_down_i)
				regs_lost_q <= 1'b1;
			else if (wr_staged)
				regs_lost_q <= 1'b0;
			osc_enable_o <= async_sel_q & ~power_down_i;
			osc_amp_enable_o <= async_sel_q & ~ext_clk_q &
				~power_down_i;
			osc_port_detach_o <= async_sel_q;
		end
	end

	// ****************************************************************
	// Avalon-MM response
	// ****************************************************************
	// Every access waits exactly one cycle; read data are captured while
	// waitrequest is still high so they stand at the accepting edge.
	always @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			waitrequest_o <= 1'b1;
			readdata_o <= 32'h0000_0000;
		end else begin
			waitrequest_o <= ~(bus_req & waitrequest_o);
			if (read_i && waitrequest_o) begin
				case (address_i)
				`OFS_COUNTER: readdata_o <= {24'h000000, cnt_hold_q};
				`OFS_CMP_A: readdata_o <= {24'h000000, dest_q[`IDX_CMP_A]};
				`OFS_CMP_B: readdata_o <= {24'h000000, dest_q[`IDX_CMP_B]};
				`OFS_CTRL_A: readdata_o <= {24'h000000, dest_q[`IDX_CTRL_A]};
				`OFS_CTRL_B: readdata_o <= {24'h000000, dest_q[`IDX_CTRL_B]};
				`OFS_STATUS: readdata_o <= {24'h000000, regs_lost_q,
					ext_clk_q, async_sel_q, busy_q[`IDX_COUNTER],
					busy_q[`IDX_CMP_A], busy_q[`IDX_CMP_B],
					busy_q[`IDX_CTRL_A], busy_q[`IDX_CTRL_B]};
				`OFS_GEN_CTRL: readdata_o <= {30'h00000000, psc_reset_q,
					1'b0};
				`OFS_FLAGS: readdata_o <= {29'h00000000, flags_q};
				`OFS_IRQ_EN: readdata_o <= {29'h00000000, irq_en_q};
				default: readdata_o <= 32'h0000_0000;
				endcase
			end
		end
	end

endmodule // async_timer_sync_prescaler

`default_nettype wire

/* File: async_timer_checker_assertions.sv */
// Checker for the bus answer, pin relations and wake pulse of the timer.
// Assumes it is bound to the timer's top module and sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module async_timer_checker (
	// ****
	// Watched ports
	// ****
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic waitrequest_o,
	input wire logic power_save_i,
	input wire logic power_down_i,
	input wire logic osc_enable_o,
	input wire logic osc_amp_enable_o,
	input wire logic osc_port_detach_o,
	input wire logic compare_out_o,
	input wire logic wake_request_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!resetn_i);
	sequence taken_s;
		(read_i || write_i) && waitrequest_o;
	endsequence
	sequence answer_s;
		!waitrequest_o ##1 waitrequest_o;
	endsequence
	bus_answer_a: assert property (taken_s |=> answer_s)
		else $error("access not answered after one wait cycle");
	idle_wait_a: assert property (
		!read_i && !write_i && waitrequest_o |=> waitrequest_o)
		else $error("waitrequest dropped with no access");
	detach_osc_a: assert property (osc_enable_o |-> osc_port_detach_o)
		else $error("oscillator on while pins attached");
	amp_osc_a: assert property (osc_amp_enable_o |-> osc_enable_o)
		else $error("amplifier on without oscillator");
	pd_stop_a: assert property (power_down_i |=> !osc_enable_o)
		else $error("oscillator kept running in power-down");
	osc_run_a: assert property (
		osc_port_detach_o && $past(osc_port_detach_o)
		&& !$past(power_down_i) && !$past(power_down_i, 2)
		|-> osc_enable_o)
		else $error("oscillator stopped outside power-down");
	wake_pulse_a: assert property (wake_request_o |=> !wake_request_o)
		else $error("wake request longer than one cycle");
	wake_sleep_a: assert property (wake_request_o |-> $past(power_save_i))
		else $error("wake request while awake");
	cmp_hold_a: assert property (
		$changed(compare_out_o) |=> $stable(compare_out_o) [*8])
		else $error("compare output changed faster than the timer clock");
endmodule // async_timer_checker
`default_nettype wire

/* File: osc_model.sv */
// Oscillator at the timer's pin, scaled up in rate for a short run.
// Assumes the timer's oscillator enable gates it.
`timescale 1ns/1ns
`default_nettype none
module osc_model #(
	// Period stays well above four system clocks, so the crossing settles.
	parameter int HALF_NS = 510
) (
	input wire logic en_i,
	output logic osc_o
);
	initial osc_o = 1'b0;
	// A stopped oscillator rests low rather than holding its last level.
	always begin
		#(HALF_NS);
		osc_o = en_i ? ~osc_o : 1'b0;
	end
endmodule // osc_model
`default_nettype wire

/* File: test_async_timer_sync_prescaler.sv */
// Testbench: Avalon-MM accesses to the timer with an oscillator model.
// Assumes the constants header, the timer, checker and model compile first.
`timescale 1ns/1ns
`default_nettype none
`include "async_timer_consts.vh"
module test_async_timer_sync_prescaler;
	logic sys_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [4:0] address_i = 5'h00;
	logic read_i = 1'b0;
	logic write_i = 1'b0;
	logic [31:0] writedata_i = 32'h0;
	logic power_save_i = 1'b0;
	logic power_down_i = 1'b0;
	wire [31:0] readdata_o;
	wire waitrequest_o, osc_input_pin_i, osc_enable_o, osc_amp_enable_o;
	wire osc_port_detach_o, compare_out_o, wake_request_o;
	int miscompares = 0;
	int num_checks = 0;
	int cyc = 0;
	int n;
	logic [7:0] v;
	logic co;
	localparam int DIV [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
	async_timer_sync_prescaler i_dut(.sys_clk_i, .resetn_i, .address_i,
		.read_i, .write_i, .writedata_i, .readdata_o, .waitrequest_o,
		.osc_input_pin_i, .power_save_i, .power_down_i, .osc_enable_o,
		.osc_amp_enable_o, .osc_port_detach_o, .compare_out_o,
		.wake_request_o);
	osc_model i_osc(.en_i(osc_enable_o), .osc_o(osc_input_pin_i));
	initial forever #50 sys_clk_i = ~sys_clk_i;
	// The tests need about 31000 cycles; the ceiling leaves room for slack.
	always @(posedge sys_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			miscompares++;
			close_out();
		end
	end
	// ****
	// Tasks
	// ****
	task automatic close_out();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string s, input logic [7:0] e, g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic chk_rng(input string s, input int lo, hi,
		input logic [7:0] g);
		num_checks++;
		if ((g >= lo && g <= hi) !== 1'b1) begin
			miscompares++;
			$display("[FAIL] %s exp %0d..%0d got %h", s, lo, hi, g);
		end
	endtask
	task automatic acc(input logic w, input logic [4:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge sys_clk_i);
		address_i <= a;
		writedata_i <= {24'h0, d};
		write_i <= w;
		read_i <= !w;
		do @(posedge sys_clk_i); while (waitrequest_o !== 1'b0);
		q = readdata_o[7:0];
		write_i <= 1'b0;
		read_i <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [7:0] q;
		acc(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [4:0] a, output logic [7:0] q);
		acc(1'b0, a, 8'h00, q);
	endtask
	// Polls status until no staged write is pending; t counts cycles.
	task automatic wait_idle(output int t);
		t = 0;
		do begin
			rd(`OFS_STATUS, v);
			t += 3;
		end while (v[4:0] !== 5'h00 && t < 300);
		chk("idle", 8'h00, {3'h0, v[4:0]});
	endtask
	// ****
	// Main sequence
	// ****
	initial begin
		repeat (3) @(posedge sys_clk_i);
		resetn_i <= 1'b1;
		rd(`OFS_STATUS, v);
		chk("status", 8'h00, v);
		chk("detach", 8'h00, {7'h0, osc_port_detach_o});
		wr(`OFS_STATUS, 8'h20);
		rd(`OFS_STATUS, v);
		chk("pins", 8'h07, {5'h0, osc_port_detach_o, osc_enable_o,
			osc_amp_enable_o});
		wr(`OFS_STATUS, 8'h60);
		rd(`OFS_STATUS, v);
		chk("ext", 8'h06, {5'h0, osc_port_detach_o, osc_enable_o,
			osc_amp_enable_o});
		wr(`OFS_CTRL_A, 8'h40);
		wr(`OFS_CMP_A, 8'h01);
		wr(`OFS_CMP_B, 8'h20);
		rd(`OFS_STATUS, v);
		chk("busy", 8'h6e, v);
		wait_idle(n);
		chk_rng("commit", 6, 60, n[7:0]);
		rd(`OFS_CMP_A, v);
		chk("cmp a", 8'h01, v);
		rd(`OFS_CMP_B, v);
		chk("cmp b", 8'h20, v);
		rd(5'h1e, v);
		chk("unmapped", 8'h00, v);
		for (int cs = 0; cs < 8; cs++) begin
			wr(`OFS_CTRL_B, 8'h00);
			wr(`OFS_COUNTER, 8'h00);
			wait_idle(n);
			wr(`OFS_GEN_CTRL, 8'h02);
			wr(`OFS_CTRL_B, cs[7:0]);
			wait_idle(n);
			repeat (20 * DIV[cs] + 1) @(posedge sys_clk_i);
			rd(`OFS_COUNTER, v);
			chk_rng("count", cs ? 1 : 0, cs ? 4 : 0, v);
		end
		wr(`OFS_FLAGS, 8'h07);
		wr(`OFS_IRQ_EN, 8'h01);
		wr(`OFS_COUNTER, 8'hfe);
		wr(`OFS_CTRL_B, {5'h0, `CS_DIV1});
		wait_idle(n);
		power_save_i <= 1'b1;
		for (n = 0; n < 200 && wake_request_o !== 1'b1; n++)
			@(posedge sys_clk_i);
		chk("wake", 8'h01, {7'h0, wake_request_o});
		power_save_i <= 1'b0;
		rd(`OFS_FLAGS, v);
		chk("flag set", 8'h01, v & 8'h01);
		wr(`OFS_FLAGS, 8'h07);
		rd(`OFS_FLAGS, v);
		chk("flag clear", 8'h00, v & 8'h01);
		// A committed write proves two timer edges passed since the wake.
		wr(`OFS_CTRL_A, 8'h40);
		wait_idle(n);
		rd(`OFS_COUNTER, v);
		chk_rng("post wake", 1, 30, v);
		power_down_i <= 1'b1;
		repeat (5) @(posedge sys_clk_i);
		chk("osc off", 8'h00, {7'h0, osc_enable_o});
		power_down_i <= 1'b0;
		repeat (30) @(posedge sys_clk_i);
		rd(`OFS_STATUS, v);
		chk("lost", 8'h80, v & 8'h80);
		// Back to the system clock, where every commit takes two cycles.
		wr(`OFS_IRQ_EN, 8'h00);
		wr(`OFS_STATUS, 8'h00);
		wr(`OFS_CTRL_B, {5'h0, `CS_STOP});
		wr(`OFS_CMP_A, 8'h41);
		wr(`OFS_COUNTER, 8'h3f);
		wait_idle(n);
		wr(`OFS_FLAGS, 8'h07);
		co = compare_out_o;
		// Counter meets 41 while the rewrite of compare A is pending.
		wr(`OFS_CTRL_B, {5'h0, `CS_DIV1});
		wr(`OFS_CMP_A, 8'h41);
		repeat (10) @(posedge sys_clk_i);
		chk("cmp blocked", {7'h0, co}, {7'h0, compare_out_o});
		rd(`OFS_FLAGS, v);
		chk("no match", 8'h00, v & 8'h02);
		repeat (300) @(posedge sys_clk_i);
		chk("cmp toggle", {7'h0, ~co}, {7'h0, compare_out_o});
		rd(`OFS_FLAGS, v);
		chk("match flag", 8'h02, v & 8'h02);
		close_out();
	end
endmodule // test_async_timer_sync_prescaler
bind async_timer_sync_prescaler async_timer_checker i_chk(.sys_clk_i,
	.resetn_i, .read_i, .write_i, .waitrequest_o, .power_save_i,
	.power_down_i, .osc_enable_o, .osc_amp_enable_o, .osc_port_detach_o,
	.compare_out_o, .wake_request_o);
`default_nettype wire
